//--- multilane_spi_pad_lane_config.sv
// Summary of operation
// - clock pad 8; strobes and upper lanes
// - device 0 lanes from 0, device 1 from 4 in serial, dual and quad
// - drive mask limits which pads are driven
// - clock moves to lane 4 except octal
// - split io takes lane 0 from pad 1, or from pad 5 for device 1
// - split io needed for separate-line serial reads
// - relocated clock adjusts drive mask to match
// - address and data widths can exceed instruction width in serial
// - mixed field widens data or address+data
// - device width select codes per chip enable
// - mixed width codes 0,1,3,5,7
// - drive mask values per mode
// - hex width only on hex-capable instances
module multilane_spi_pad_lane_config
   import mspc_pkg::*;
#(
   parameter bit HEX_CAPABLE = 1'b1,
   parameter int SCLK_DIV = 2
) (
   input wire logic clk, // core clock
   input wire logic rst_b, // async reset, active low
   input wire logic linkClk, // link clock
   input wire logic [4:0] device_width_select, // width and chip enable code
   input wire logic split_io_dev0, // separate miso for device 0
   input wire logic split_io_dev1, // separate miso for device 1
   input wire logic clock_on_lane_four, // move clock to lane 4
   input wire logic pio_mode, // 1 selects pio mix field
   input wire logic [2:0] pio_phase_width_mix, // pio mix code
   input wire logic [2:0] xip_phase_width_mix0, // xip mix code dev 0
   input wire logic [2:0] xip_phase_width_mix1, // xip mix code dev 1
   input wire logic clockRun, // serial clock enable
   input wire logic [15:0] txLanes, // transmit lane data
   input wire logic [1:0] txStrobe, // strobe or mask out
   input wire logic [18:0] padIn, // pad input levels
   output logic [18:0] padOut, // pad output levels
   output logic [18:0] padOe, // pad drive enables
   output logic [18:0] pad_drive_mask, // drive mask in use
   output logic [15:0] rxLanes, // received lane data, link domain
   output logic chipEnable1, // selected chip enable
   output logic configValid, // code is legal here
   output logic [4:0] instrWidth, // instruction lanes
   output logic [4:0] addrWidth, // address lanes
   output logic [4:0] dataWidth // data lanes
);
   // ==========================================================
   // configuration state fields
   typedef struct packed {
      mspc_mode_t mode;
      logic ce1;
      logic onD4;
      logic splitIo;
      logic lowDev1; // device 1 on lanes 4 to 7
      logic run;
      logic valid;
      logic [18:0] mask;
      logic [4:0] iw;
      logic [4:0] aw;
      logic [4:0] dw;
   } mspc_state_t;
   mspc_state_t cs;
   mspc_state_t next_cs;
   // ==========================================================
   // link reset and clock enable synchronisation
   logic [1:0] linkRstSync;
   logic [1:0] runSync;
   logic linkRst_b;
   logic sclk;
   always_ff @(posedge linkClk or negedge rst_b) begin
      if (!rst_b) begin
         linkRstSync <= 2'b00;
      end else begin
         linkRstSync <= {linkRstSync[0], 1'b1};
      end
   end
   assign linkRst_b = linkRstSync[1];
   always_ff @(posedge linkClk or negedge linkRst_b) begin
      if (!linkRst_b) begin
         runSync <= 2'b00;
      end else begin
         runSync <= {runSync[0], cs.run};
      end
   end
   mspc_sclk_gen #(.DIV(SCLK_DIV)) uGen (
      .linkClk(linkClk),
      .linkRst_b(linkRst_b),
      .run(runSync[1]),
      .sclk(sclk)
   );
   // ==========================================================
   // decode
   function automatic mspc_mode_t decodeMode(input logic [4:0] code);
      unique case (code)
         MSPC_CFG_SERIAL0, MSPC_CFG_SERIAL1: decodeMode = MSPC_SERIAL;
         MSPC_CFG_DUAL0, MSPC_CFG_DUAL1: decodeMode = MSPC_DUAL;
         MSPC_CFG_QUAD0, MSPC_CFG_QUAD1: decodeMode = MSPC_QUAD;
         MSPC_CFG_OCTAL0, MSPC_CFG_OCTAL1: decodeMode = MSPC_OCTAL;
         MSPC_CFG_HEX0, MSPC_CFG_HEX1: decodeMode = HEX_CAPABLE ? MSPC_HEX : MSPC_OFF;
         default: decodeMode = MSPC_OFF;
      endcase
   endfunction
   function automatic logic [18:0] maskFor(input mspc_mode_t m, input logic ce1, input logic onD4);
      logic [18:0] mk;
      mk = MSPC_MASK_NONE;
      unique case (m)
         MSPC_SERIAL: mk = ce1 ? MSPC_MASK_S1 : MSPC_MASK_S0;
         MSPC_DUAL: mk = ce1 ? MSPC_MASK_D1 : MSPC_MASK_D0;
         MSPC_QUAD: mk = ce1 ? MSPC_MASK_Q1 : MSPC_MASK_Q0;
         MSPC_OCTAL: mk = MSPC_MASK_OCT;
         MSPC_HEX: mk = MSPC_MASK_HEX;
         MSPC_OFF: mk = MSPC_MASK_NONE;
      endcase
      if (onD4 && m != MSPC_OCTAL && m != MSPC_OFF) begin
         mk[MSPC_PAD_CLK] = 1'b0;
         mk[MSPC_PAD_LANE4] = 1'b1;
      end
      maskFor = mk;
   endfunction
   function automatic logic [4:0] modeWidth(input mspc_mode_t m);
      unique case (m)
         MSPC_SERIAL: modeWidth = MSPC_W1;
         MSPC_DUAL: modeWidth = MSPC_W2;
         MSPC_QUAD: modeWidth = MSPC_W4;
         MSPC_OCTAL: modeWidth = MSPC_W8;
         MSPC_HEX: modeWidth = MSPC_W16;
         MSPC_OFF: modeWidth = MSPC_W1;
      endcase
   endfunction
   // ==========================================================
   // registered configuration state
   always_comb begin
      logic [2:0] mix;
      mspc_mode_t m;
      logic c1;
      logic d4;
      mix = MSPC_MIX_NORMAL;
      m = decodeMode(device_width_select);
      c1 = (device_width_select == MSPC_CFG_SERIAL1) || (device_width_select == MSPC_CFG_DUAL1) ||
           (device_width_select == MSPC_CFG_QUAD1) || (device_width_select == MSPC_CFG_OCTAL1) ||
           (device_width_select == MSPC_CFG_HEX1);
      d4 = clock_on_lane_four && (m != MSPC_OCTAL) && (m != MSPC_OFF);
      next_cs = cs;
      next_cs.mode = m;
      next_cs.ce1 = c1;
      next_cs.onD4 = d4;
      next_cs.splitIo = (m == MSPC_SERIAL) && (c1 ? split_io_dev1 : split_io_dev0);
      next_cs.lowDev1 = c1 && (m != MSPC_OCTAL) && (m != MSPC_HEX);
      next_cs.valid = (m != MSPC_OFF);
      next_cs.run = clockRun && (m != MSPC_OFF);
      next_cs.mask = maskFor(m, c1, d4);
      next_cs.iw = modeWidth(m);
      next_cs.aw = modeWidth(m);
      next_cs.dw = modeWidth(m);
      mix = pio_mode ? pio_phase_width_mix : (c1 ? xip_phase_width_mix1 : xip_phase_width_mix0);
      if (m == MSPC_SERIAL) begin
         unique case (mix)
            MSPC_MIX_DATA_DUAL_ONLY: next_cs.dw = MSPC_W2;
            MSPC_MIX_ADDR_DATA_DUAL: begin
               next_cs.aw = MSPC_W2;
               next_cs.dw = MSPC_W2;
            end
            MSPC_MIX_DATA_QUAD_ONLY: next_cs.dw = MSPC_W4;
            MSPC_MIX_ADDR_DATA_QUAD: begin
               next_cs.aw = MSPC_W4;
               next_cs.dw = MSPC_W4;
            end
            default: next_cs.dw = MSPC_W1;
         endcase
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cs <= '{mode: MSPC_OFF, mask: MSPC_MASK_NONE, iw: MSPC_W1, aw: MSPC_W1, dw: MSPC_W1, default: '0};
      end else begin
         cs <= next_cs;
      end
   end
   // ==========================================================
   // pad mux, combinational from registered config and link signals
   mspc_link_if lnk();
   always_comb begin
      logic [18:0] o;
      o = '0;
      if (cs.mode == MSPC_SERIAL || cs.mode == MSPC_DUAL || cs.mode == MSPC_QUAD) begin
         for (int i = 0; i < 4; i++) begin
            o[(cs.ce1 ? MSPC_DEV1_LANE_BASE : 0) + i] = txLanes[i];
         end
      end else begin
         o[7:0] = txLanes[7:0];
         o[MSPC_PAD_DQS0] = txStrobe[0];
         o[MSPC_PAD_HIGH_LO +: 8] = txLanes[15:8];
         o[MSPC_PAD_DQS1] = txStrobe[1];
      end
      if (cs.onD4) begin
         o[MSPC_PAD_LANE4] = sclk;
      end else begin
         o[MSPC_PAD_CLK] = sclk;
      end
      lnk.padOut = o;
      lnk.padOe = cs.mask;
      lnk.sclk = sclk;
   end
   // ==========================================================
   // receive lanes captured in the link domain
   logic [18:0] padSync0;
   logic [18:0] padSync1;
   logic [15:0] rxReg;
   // settings are static during a transfer; after a change the bits may land one link edge apart
   logic [2:0] cfgSync0;
   logic [2:0] cfgSync1;
   always_ff @(posedge linkClk or negedge linkRst_b) begin
      if (!linkRst_b) begin
         cfgSync0 <= 3'h0;
         cfgSync1 <= 3'h0;
      end else begin
         cfgSync0 <= {cs.splitIo, cs.ce1, cs.lowDev1};
         cfgSync1 <= cfgSync0;
      end
   end
   always_ff @(posedge linkClk or negedge linkRst_b) begin
      if (!linkRst_b) begin
         padSync0 <= '0;
         padSync1 <= '0;
      end else begin
         padSync0 <= padIn;
         padSync1 <= padSync0;
      end
   end
   always_ff @(posedge linkClk or negedge linkRst_b) begin
      if (!linkRst_b) begin
         rxReg <= '0;
      end else begin
         rxReg <= {padSync1[17:10], padSync1[7:0]};
         if (cfgSync1[2]) begin
            rxReg[0] <= cfgSync1[1] ? padSync1[MSPC_DEV1_LANE_BASE + 1] : padSync1[MSPC_PAD_MISO];
         end else if (cfgSync1[0]) begin
            rxReg[3:0] <= padSync1[7:4];
         end
      end
   end
   assign lnk.padIn = padIn;
   assign lnk.rxLanes = rxReg;
   assign padOut = lnk.padOut;
   assign padOe = lnk.padOe;
   assign rxLanes = lnk.rxLanes;
   assign pad_drive_mask = cs.mask;
   assign chipEnable1 = cs.ce1;
   assign configValid = cs.valid;
   assign instrWidth = cs.iw;
   assign addrWidth = cs.aw;
   assign dataWidth = cs.dw;
   // ==========================================================
   // checks
   clock_move_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
      (cs.onD4 && cs.mode == MSPC_SERIAL && !cs.ce1) |-> (padOe == 19'h0_0011))
      else $error("relocated serial mask wrong");
   serial_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
      ($past(device_width_select) == MSPC_CFG_SERIAL1 && !$past(clock_on_lane_four)) |-> (padOe == MSPC_MASK_S1))
      else $error("serial ce1 mask wrong");
   octal_clock_a: assert property (@(posedge clk) disable iff (!rst_b)
      (cs.mode == MSPC_OCTAL) |-> (padOe == MSPC_MASK_OCT && !cs.onD4))
      else $error("octal clock relocated");
   hex_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
      (cs.mode == MSPC_HEX) |-> ((padOe | (19'h0_0001 << MSPC_PAD_CLK)) == MSPC_MASK_HEX &&
      padOe[MSPC_PAD_CLK] == !cs.onD4))
      else $error("hex mask wrong");
   split_serial_a: assert property (@(posedge clk) disable iff (!rst_b)
      cs.splitIo |-> (cs.mode == MSPC_SERIAL))
      else $error("split io outside serial");
   mix_quad_a: assert property (@(posedge clk) disable iff (!rst_b)
      (decodeMode(device_width_select) == MSPC_SERIAL && pio_mode && pio_phase_width_mix == MSPC_MIX_ADDR_DATA_QUAD)
      |=> (addrWidth == MSPC_W4 && dataWidth == MSPC_W4 && instrWidth == MSPC_W1))
      else $error("quad addr data mix wrong");
   invalid_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
      !cs.valid |-> (padOe == MSPC_MASK_NONE))
      else $error("pads driven when invalid");
   dev1_lanes_a: assert property (@(posedge clk) disable iff (!rst_b)
      (cs.mode == MSPC_QUAD && cs.ce1 && !cs.onD4) |-> (padOe[3:0] == 4'h0 && padOe[7:4] == 4'hF))
      else $error("device 1 lanes wrong");
   relocated_clock_a: assert property (@(posedge clk) disable iff (!rst_b)
      cs.onD4 |-> (!padOe[MSPC_PAD_CLK] && padOe[MSPC_PAD_LANE4] && padOut[MSPC_PAD_LANE4] == sclk))
      else $error("clock not moved to lane 4");
   clock_pad_a: assert property (@(posedge clk) disable iff (!rst_b)
      (cs.valid && !cs.onD4) |-> (padOe[MSPC_PAD_CLK] && padOut[MSPC_PAD_CLK] == sclk))
      else $error("clock pad not driven");
   hex_upper_a: assert property (@(posedge clk) disable iff (!rst_b)
      (cs.mode != MSPC_HEX) |-> (padOe[MSPC_PAD_DQS1:MSPC_PAD_HIGH_LO] == 9'h000))
      else $error("upper lanes driven outside hex");
   strobe_pad_a: assert property (@(posedge clk) disable iff (!rst_b)
      (cs.mode == MSPC_SERIAL || cs.mode == MSPC_DUAL || cs.mode == MSPC_QUAD) |-> !padOe[MSPC_PAD_DQS0])
      else $error("strobe pad driven in narrow mode");
   serial_dev0_a: assert property (@(posedge clk) disable iff (!rst_b)
      (cs.mode == MSPC_SERIAL && !cs.ce1 && !cs.onD4) |-> (padOe == MSPC_MASK_S0))
      else $error("serial ce0 mask wrong");
   dual_dev1_a: assert property (@(posedge clk) disable iff (!rst_b)
      (cs.mode == MSPC_DUAL && cs.ce1 && !cs.onD4) |-> (padOe == MSPC_MASK_D1))
      else $error("dual ce1 mask wrong");
   uniform_width_a: assert property (@(posedge clk) disable iff (!rst_b)
      (cs.mode != MSPC_SERIAL) |-> (instrWidth == addrWidth && addrWidth == dataWidth))
      else $error("mixed widths outside serial");
   invalid_code_a: assert property (@(posedge clk) disable iff (!rst_b)
      (decodeMode(device_width_select) == MSPC_OFF) |=> !configValid)
      else $error("illegal code accepted");
endmodule

//--- mspc_pkg.sv
package mspc_pkg;
   // ==========================================================
   // pad indices
   localparam int MSPC_NUM_PADS = 19;
   localparam int MSPC_PAD_CLK = 8;
   localparam int MSPC_PAD_DQS0 = 9;
   localparam int MSPC_PAD_DQS1 = 18;
   localparam int MSPC_PAD_MISO = 1;
   localparam int MSPC_PAD_D0 = 0;
   localparam int MSPC_PAD_LANE4 = 4;
   localparam int MSPC_PAD_HIGH_LO = 10;
   localparam int MSPC_DEV1_LANE_BASE = 4;
   // ==========================================================
   // device width select codes
   localparam logic [4:0] MSPC_CFG_SERIAL0 = 5'h01;
   localparam logic [4:0] MSPC_CFG_SERIAL1 = 5'h02;
   localparam logic [4:0] MSPC_CFG_DUAL0 = 5'h05;
   localparam logic [4:0] MSPC_CFG_DUAL1 = 5'h06;
   localparam logic [4:0] MSPC_CFG_QUAD0 = 5'h09;
   localparam logic [4:0] MSPC_CFG_QUAD1 = 5'h0A;
   localparam logic [4:0] MSPC_CFG_OCTAL0 = 5'h0D;
   localparam logic [4:0] MSPC_CFG_OCTAL1 = 5'h0E;
   localparam logic [4:0] MSPC_CFG_HEX0 = 5'h11;
   localparam logic [4:0] MSPC_CFG_HEX1 = 5'h12;
   // ==========================================================
   // phase width mix codes
   localparam logic [2:0] MSPC_MIX_NORMAL = 3'h0;
   localparam logic [2:0] MSPC_MIX_DATA_DUAL_ONLY = 3'h1;
   localparam logic [2:0] MSPC_MIX_ADDR_DATA_DUAL = 3'h3;
   localparam logic [2:0] MSPC_MIX_DATA_QUAD_ONLY = 3'h5;
   localparam logic [2:0] MSPC_MIX_ADDR_DATA_QUAD = 3'h7;
   // ==========================================================
   // drive masks
   localparam logic [18:0] MSPC_MASK_S0 = 19'h0_0101;
   localparam logic [18:0] MSPC_MASK_S1 = 19'h0_0110;
   localparam logic [18:0] MSPC_MASK_D0 = 19'h0_0103;
   localparam logic [18:0] MSPC_MASK_D1 = 19'h0_0130;
   localparam logic [18:0] MSPC_MASK_Q0 = 19'h0_010F;
   localparam logic [18:0] MSPC_MASK_Q1 = 19'h0_01F0;
   localparam logic [18:0] MSPC_MASK_OCT = 19'h0_03FF;
   localparam logic [18:0] MSPC_MASK_HEX = 19'h7_FFFF;
   localparam logic [18:0] MSPC_MASK_NONE = 19'h0_0000;
   // lane widths in lanes
   localparam logic [4:0] MSPC_W1 = 5'h01;
   localparam logic [4:0] MSPC_W2 = 5'h02;
   localparam logic [4:0] MSPC_W4 = 5'h04;
   localparam logic [4:0] MSPC_W8 = 5'h08;
   localparam logic [4:0] MSPC_W16 = 5'h10;
   typedef enum logic [2:0] {MSPC_SERIAL, MSPC_DUAL, MSPC_QUAD, MSPC_OCTAL, MSPC_HEX, MSPC_OFF} mspc_mode_t;
endpackage

//--- mspc_link_if.sv
interface mspc_link_if;
   logic [18:0] padIn;
   logic [18:0] padOut;
   logic [18:0] padOe;
   logic sclk;
   logic [15:0] rxLanes;
   modport core (input padIn, output padOut, output padOe, output sclk, output rxLanes);
   modport map (output padIn, input padOut, input padOe, input sclk, input rxLanes);
endinterface

//--- mspc_sclk_gen.sv
module mspc_sclk_gen
   import mspc_pkg::*;
#(
   parameter int DIV = 2
) (
   input wire logic linkClk, // link domain clock
   input wire logic linkRst_b, // link-domain reset, active low
   input wire logic run, // synchronised enable
   output logic sclk // serial clock out
);
   typedef struct packed {
      logic [7:0] cnt;
      logic sclk;
   } mspc_gen_t;
   mspc_gen_t st;
   mspc_gen_t next_st;
   always_comb begin
      next_st = st;
      if (!run) begin
         next_st.cnt = 8'h00;
         next_st.sclk = 1'b0;
      end else if (st.cnt == 8'(DIV - 1)) begin
         next_st.cnt = 8'h00;
         next_st.sclk = ~st.sclk;
      end else begin
         next_st.cnt = st.cnt + 8'h01;
      end
   end
   always_ff @(posedge linkClk or negedge linkRst_b) begin
      if (!linkRst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign sclk = st.sclk;
endmodule

//--- mspc_flash_model.sv
module mspc_flash_model
   import mspc_pkg::*;
#(
   parameter logic [18:0] RESP = 19'h5_A5A2
) (
   input wire logic [18:0] padOut, // levels the manager drives
   input wire logic [18:0] padOe, // pads the manager drives
   output logic [18:0] padIn // resolved pad levels
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // wire resolution: the memory answers on every pad left undriven
   always_comb begin
      for (int i = 0; i < MSPC_NUM_PADS; i++) begin
         padIn[i] = padOe[i] ? padOut[i] : RESP[i];
      end
   end
endmodule

//--- tb_multilane_spi_pad_lane_config.sv
module tb_multilane_spi_pad_lane_config
   import mspc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin fails++; \
   $display("BAD %s exp %h got %h", nm, ex, gt); end end
   logic clk = 1'b0, rst_b, linkClk = 1'b0;
   logic [4:0] code = 5'h01;
   logic sio0 = 1'b0, sio1 = 1'b0, lane4 = 1'b0, pioMode = 1'b1, clockRun = 1'b0;
   logic [2:0] pioMix = 3'h0, xipMix0 = 3'h0, xipMix1 = 3'h0;
   logic [15:0] txLanes = 16'h0000;
   logic [1:0] txStrobe = 2'h0;
   logic [18:0] padIn, padOut, padOe, mask;
   logic [15:0] rxLanes;
   logic ce1, cfgOk;
   logic [4:0] iW, aW, dW;
   int fails = 0, cmp_count = 0, cycles = 0;
   logic [4:0] codes[10] = '{5'h01, 5'h02, 5'h05, 5'h06, 5'h09, 5'h0A, 5'h0D, 5'h0E, 5'h11, 5'h12};
   logic [18:0] masks[10] = '{MSPC_MASK_S0, MSPC_MASK_S1, MSPC_MASK_D0, MSPC_MASK_D1, MSPC_MASK_Q0,
      MSPC_MASK_Q1, MSPC_MASK_OCT, MSPC_MASK_OCT, MSPC_MASK_HEX, MSPC_MASK_HEX};
   logic [2:0] mixes[5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7};
   logic [14:0] mixW[5] = '{15'h0421, 15'h0422, 15'h0442, 15'h0424, 15'h0484};
   initial forever #12.5 clk = ~clk;
   initial begin
      #7;
      forever #62.5 linkClk = ~linkClk;
   end
   multilane_spi_pad_lane_config i_multilane_spi_pad_lane_config (.clk(clk), .rst_b(rst_b),
      .linkClk(linkClk), .device_width_select(code), .split_io_dev0(sio0), .split_io_dev1(sio1),
      .clock_on_lane_four(lane4), .pio_mode(pioMode), .pio_phase_width_mix(pioMix),
      .xip_phase_width_mix0(xipMix0), .xip_phase_width_mix1(xipMix1), .clockRun(clockRun),
      .txLanes(txLanes), .txStrobe(txStrobe), .padIn(padIn), .padOut(padOut), .padOe(padOe),
      .pad_drive_mask(mask), .rxLanes(rxLanes), .chipEnable1(ce1), .configValid(cfgOk),
      .instrWidth(iW), .addrWidth(aW), .dataWidth(dW));
   mspc_flash_model i_mspc_flash_model (.padOut(padOut), .padOe(padOe), .padIn(padIn));
   // ==========================================================
   // helpers
   task automatic settle();
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic setCfg(input logic [4:0] c, input logic l4);
      @(posedge clk);
      code <= c;
      lane4 <= l4;
      settle();
   endtask
   task automatic countToggles(input int pad, output int n);
      logic last;
      n = 0;
      last = padOut[pad];
      repeat (60) begin
         @(negedge clk);
         if (padOut[pad] !== last) n++;
         last = padOut[pad];
      end
   endtask
   // ==========================================================
   // scenarios
   task automatic maskTable();
      for (int i = 0; i < 10; i++) begin
         setCfg(codes[i], 1'b0);
         `CHK("mask", masks[i], mask)
         `CHK("padOe", masks[i], padOe)
         `CHK("ce1", (i % 2 == 1), ce1)
         `CHK("valid", 1'b1, cfgOk)
      end
      setCfg(5'h03, 1'b0);
      `CHK("badValid", 1'b0, cfgOk)
      `CHK("badOe", MSPC_MASK_NONE, padOe)
   endtask
   task automatic relocate();
      setCfg(MSPC_CFG_SERIAL0, 1'b1);
      `CHK("relocS", 19'h0_0011, padOe)
      setCfg(MSPC_CFG_DUAL0, 1'b1);
      `CHK("relocD", 19'h0_0013, padOe)
      setCfg(MSPC_CFG_QUAD0, 1'b1);
      `CHK("relocQ", 19'h0_001F, padOe)
      setCfg(MSPC_CFG_HEX0, 1'b1);
      `CHK("relocHex", 19'h7_FEFF, padOe)
      setCfg(MSPC_CFG_OCTAL1, 1'b1);
      `CHK("relocOct", MSPC_MASK_OCT, padOe)
   endtask
   task automatic clockPads();
      int n;
      @(posedge clk);
      clockRun <= 1'b1;
      setCfg(MSPC_CFG_SERIAL0, 1'b0);
      countToggles(MSPC_PAD_CLK, n);
      `CHK("clkPad8", 1'b1, n > 2)
      setCfg(MSPC_CFG_SERIAL0, 1'b1);
      countToggles(MSPC_PAD_LANE4, n);
      `CHK("clkPad4", 1'b1, n > 2)
      countToggles(MSPC_PAD_CLK, n);
      `CHK("clkPad8Off", 0, n)
      @(posedge clk);
      clockRun <= 1'b0;
   endtask
   task automatic mixWidths();
      @(posedge clk);
      pioMode <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         pioMix <= mixes[i];
         setCfg(MSPC_CFG_SERIAL0, 1'b0);
         `CHK("pioW", mixW[i], {iW, aW, dW})
      end
      @(posedge clk);
      pioMode <= 1'b0;
      xipMix0 <= 3'h3;
      xipMix1 <= 3'h7;
      setCfg(MSPC_CFG_SERIAL1, 1'b0);
      `CHK("xip1W", {MSPC_W1, MSPC_W4, MSPC_W4}, {iW, aW, dW})
      setCfg(MSPC_CFG_SERIAL0, 1'b0);
      `CHK("xip0W", {MSPC_W1, MSPC_W2, MSPC_W2}, {iW, aW, dW})
      setCfg(MSPC_CFG_QUAD0, 1'b0);
      `CHK("quadW", {MSPC_W4, MSPC_W4, MSPC_W4}, {iW, aW, dW})
   endtask
   task automatic txRoute();
      @(posedge clk);
      txLanes <= 16'hA5CB;
      txStrobe <= 2'h2;
      setCfg(MSPC_CFG_QUAD1, 1'b0);
      `CHK("dev1Tx", 4'hB, padOut[7:4])
      setCfg(MSPC_CFG_HEX0, 1'b0);
      `CHK("hexLo", 8'hCB, padOut[7:0])
      `CHK("hexHi", 8'hA5, padOut[17:10])
      `CHK("hexStb", 2'h2, {padOut[18], padOut[9]})
   endtask
   task automatic splitRx();
      @(posedge clk);
      txLanes <= 16'h0000;
      sio0 <= 1'b0;
      setCfg(MSPC_CFG_SERIAL0, 1'b0);
      repeat (5) @(posedge linkClk);
      @(negedge clk);
      `CHK("rxShared", 1'b0, rxLanes[0])
      @(posedge clk);
      sio0 <= 1'b1;
      repeat (5) @(posedge linkClk);
      @(negedge clk);
      `CHK("rxSplit0", 1'b1, rxLanes[0])
      @(posedge clk);
      sio1 <= 1'b1;
      setCfg(MSPC_CFG_SERIAL1, 1'b0);
      repeat (5) @(posedge linkClk);
      @(negedge clk);
      `CHK("rxSplit1", 1'b1, rxLanes[0])
   endtask
   // ==========================================================
   // verdict
   task automatic close_out();
      if (fails == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         fails++;
         close_out();
      end
   end
   initial begin
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      settle();
      maskTable();
      relocate();
      clockPads();
      mixWidths();
      txRoute();
      splitRx();
      close_out();
   end
endmodule
